// File: core/iocr_regs.vh
// register offsets, field positions and route codes for the configuration slice
`ifndef IOCR_REGS_VH
`define IOCR_REGS_VH
`define IOCR_ADDR_W 16
`define IOCR_ENGINE_CONTROL 16'h2000
`define IOCR_REFERENCE_CHOP_CONTROL 16'h2002
`define IOCR_COMPARATOR_CONTROL_STATUS 16'h2003
`define IOCR_ANALOG_MISC_CONTROL 16'h2004
`define IOCR_CONVERTER_POWER_CONTROL 16'h2005
`define IOCR_PIN_ROUTE_PAIR_A 16'h2009
`define IOCR_PIN_ROUTE_PAIR_B 16'h200A
`define IOCR_PIN_ROUTE_PAIR_C 16'h200B
`define IOCR_PIN_ROUTE_PAIR_D 16'h200C
`define IOCR_PIN_ROUTE_PAIR_E 16'h200D
`define IOCR_PIN_ROUTE_PAIR_F 16'h200E
`define IOCR_IRQ_STATUS 16'h2010
`define IOCR_IRQ_MASK 16'h2011
`define IOCR_ENGINE_ENABLE_BIT 4
`define IOCR_CHOP_LO_BIT 4
`define IOCR_CHOP_HI_BIT 5
`define IOCR_COMP_INT_LO_BIT 3
`define IOCR_COMP_INT_HI_BIT 4
`define IOCR_MISC_RESERVED_BIT 5
`define IOCR_CONVERTER_DISABLE_BIT 3
`define IOCR_RESET_BYTE 8'h00
`define IOCR_ROUTE_NONE 3'h0
`define IOCR_ROUTE_COUNTER0 3'h2
`define IOCR_ROUTE_COUNTER1 3'h3
`define IOCR_ROUTE_HP_RISE 3'h4
`define IOCR_ROUTE_LP_RISE 3'h5
`define IOCR_ROUTE_HP_FALL 3'h6
`define IOCR_ROUTE_LP_FALL 3'h7
`define IOCR_NUM_PINS 12
`endif

// File: core/iocr_sync.v
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module iocr_sync #(
   parameter W = 15
) (
   input wire clk,
   input wire reset,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         meta <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// File: core/iocr_config_slice.v
// configuration register slice with comparator interrupts and pin routing
// Functional notes
// RL1: a set converter disable bit powers the converter down and removes its bias.
// RL2: chop codes 00 and 11 enable reference chopping, 01 and 10 disable it.
// RL3: each comparator interrupt enable bit lets a state change of its comparator interrupt.
// RL4: with both enable bits set the interrupt follows changes of the XOR of the two outputs.
// RL5: enable bit zero governs the second comparator and bit one the third.
// RL6: the read-only state field shows the first, second and third comparators in bits 0..2.
// RL7: each of the twelve pins has its own resource selector.
// RL8: pins selecting the same resource are OR-combined.
// RL9: selectors are three bits: 0 none, 1 reserved, 2 counter0 clock, 3 counter1 clock.
// RL10: codes 4 and 6 feed the high-priority interrupt on rise and fall, 5 and 7 the low one.
// RL11: every configuration bit clears to zero at power-up.
// RL12: selectors pack two per byte, even pin in bits 2..0, odd pin in bits 6..4.
// RL13: the reserved misc bit five is written zero by software and held at zero.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "iocr_regs.vh"
module iocr_config_slice (
   input wire clk,
   input wire reset,
   input wire [15:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire first_comparator,
   input wire second_comparator,
   input wire third_comparator,
   input wire [11:0] pin_in,
   output reg converter_disable,
   output reg converter_bias_off,
   output reg engine_enable,
   output reg reference_chop_enable,
   output reg [7:0] analog_misc,
   output reg counter0_clock_input,
   output reg counter1_clock_input,
   output reg high_priority_pin_interrupt,
   output reg low_priority_pin_interrupt,
   output reg comparator_irq,
   output reg irq
);
   reg [7:0] engine_control;
   reg [7:0] reference_chop_control;
   reg [1:0] comp_int_enable;
   reg [7:0] analog_misc_control;
   reg [7:0] converter_power_control;
   reg [2:0] pin_resource_selector [0:11];
   reg [1:0] irq_status;
   reg [1:0] irq_mask;
   reg [2:0] comp_prev;
   reg [11:0] pin_prev;
   reg [1:0] next_irq_status;
   reg [11:0] hp_r, lp_r, c0, c1;
   wire [14:0] sync_q;
   wire [2:0] comp_now;
   wire [11:0] pin_now;
   wire [11:0] pin_rise;
   wire [11:0] pin_fall;
   wire comp_event;
   wire second_comparator_change;
   wire third_comparator_change;
   wire both_enabled;
   wire [1:0] status_set;
   wire [1:0] status_clear;
   reg [7:0] next_rdata;
   integer i;
   integer j;
   integer k;

   // two stages before any logic reads a pin or comparator
   iocr_sync #(.W(15)) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({third_comparator, second_comparator, first_comparator, pin_in}),
      .sync_out(sync_q)
   );
   assign comp_now = sync_q[14:12];
   assign pin_now = sync_q[11:0];
   assign pin_rise = pin_now & ~pin_prev;
   assign pin_fall = ~pin_now & pin_prev;

   // pin index of a byte address, 4'hF when not a route register
   function [3:0] pair_base;
      input [15:0] a;
      begin
         if (a >= `IOCR_PIN_ROUTE_PAIR_A && a <= `IOCR_PIN_ROUTE_PAIR_F)
            pair_base = {a[2:0] - 3'h1, 1'b0};
         else
            pair_base = 4'hF;
      end
   endfunction

   // pin route packing
   function [7:0] pack_pair;
      input [2:0] even_sel;
      input [2:0] odd_sel;
      begin
         pack_pair = {1'b0, odd_sel, 1'b0, even_sel};
      end
   endfunction

   // RL5 bit zero follows the second comparator, bit one the third
   assign second_comparator_change = comp_now[1] ^ comp_prev[1];
   assign third_comparator_change = comp_now[2] ^ comp_prev[2];

   // RL4 xor combining
   assign both_enabled = (comp_int_enable == 2'h3);
   assign comp_event = (comp_now[1] ^ comp_now[2]) != (comp_prev[1] ^ comp_prev[2]);

   // RL3 per comparator events
   // with both enables set only bit zero can set
   assign status_set[0] = both_enabled ? comp_event : (comp_int_enable[0] & second_comparator_change);
   assign status_set[1] = ~both_enabled & comp_int_enable[1] & third_comparator_change;
   assign status_clear = (wr && addr == `IOCR_IRQ_STATUS) ? wdata[1:0] : 2'h0;

   // sticky status bits, an event wins over a clear in the same cycle
   always @* begin
      next_irq_status = (irq_status & ~status_clear) | status_set;
   end

   // RL8 or combining of routed pins
   // RL9 counter clock selection
   always @* begin
      c0 = 12'h000;
      c1 = 12'h000;
      for (i = 0; i < `IOCR_NUM_PINS; i = i + 1) begin
         if (pin_resource_selector[i] == `IOCR_ROUTE_COUNTER0)
            c0[i] = pin_now[i];
         if (pin_resource_selector[i] == `IOCR_ROUTE_COUNTER1)
            c1[i] = pin_now[i];
      end
   end

   // RL10 edge interrupt codes
   always @* begin
      hp_r = 12'h000;
      lp_r = 12'h000;
      for (k = 0; k < `IOCR_NUM_PINS; k = k + 1) begin
         case (pin_resource_selector[k])
            `IOCR_ROUTE_HP_RISE: hp_r[k] = pin_rise[k];
            `IOCR_ROUTE_LP_RISE: lp_r[k] = pin_rise[k];
            `IOCR_ROUTE_HP_FALL: hp_r[k] = pin_fall[k];
            `IOCR_ROUTE_LP_FALL: lp_r[k] = pin_fall[k];
            // codes 0 to 3 raise no edge event
            default: hp_r[k] = 1'b0;
         endcase
      end
   end

   // RL11 zero at reset
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         engine_control <= `IOCR_RESET_BYTE;
         reference_chop_control <= `IOCR_RESET_BYTE;
         comp_int_enable <= 2'h0;
         analog_misc_control <= `IOCR_RESET_BYTE;
         converter_power_control <= `IOCR_RESET_BYTE;
         irq_mask <= 2'h0;
         for (j = 0; j < `IOCR_NUM_PINS; j = j + 1)
            pin_resource_selector[j] <= `IOCR_ROUTE_NONE;
      end else if (wr) begin
         case (addr)
            `IOCR_ENGINE_CONTROL: engine_control <= wdata;
            `IOCR_REFERENCE_CHOP_CONTROL: reference_chop_control <= wdata;
            `IOCR_COMPARATOR_CONTROL_STATUS:
               comp_int_enable <= wdata[`IOCR_COMP_INT_HI_BIT:`IOCR_COMP_INT_LO_BIT];
            // RL13 reserved bit held zero
            `IOCR_ANALOG_MISC_CONTROL: begin
               analog_misc_control <= wdata;
               analog_misc_control[`IOCR_MISC_RESERVED_BIT] <= 1'b0;
            end
            `IOCR_CONVERTER_POWER_CONTROL: converter_power_control <= wdata;
            `IOCR_IRQ_MASK: irq_mask <= wdata[1:0];
            // RL7 independent selectors
            // RL12 two per byte
            `IOCR_PIN_ROUTE_PAIR_A: begin
               pin_resource_selector[0] <= wdata[2:0];
               pin_resource_selector[1] <= wdata[6:4];
            end
            `IOCR_PIN_ROUTE_PAIR_B: begin
               pin_resource_selector[2] <= wdata[2:0];
               pin_resource_selector[3] <= wdata[6:4];
            end
            `IOCR_PIN_ROUTE_PAIR_C: begin
               pin_resource_selector[4] <= wdata[2:0];
               pin_resource_selector[5] <= wdata[6:4];
            end
            `IOCR_PIN_ROUTE_PAIR_D: begin
               pin_resource_selector[6] <= wdata[2:0];
               pin_resource_selector[7] <= wdata[6:4];
            end
            `IOCR_PIN_ROUTE_PAIR_E: begin
               pin_resource_selector[8] <= wdata[2:0];
               pin_resource_selector[9] <= wdata[6:4];
            end
            `IOCR_PIN_ROUTE_PAIR_F: begin
               pin_resource_selector[10] <= wdata[2:0];
               pin_resource_selector[11] <= wdata[6:4];
            end
            default: begin
            end
         endcase
      end
   end

   // RL6 live comparator state beside the enables
   // RL7 each selector reads back on its own
   // RL12 route bytes pack two selectors
   always @* begin
      // reads outside the map return zero
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `IOCR_ENGINE_CONTROL: next_rdata = engine_control;
            `IOCR_REFERENCE_CHOP_CONTROL: next_rdata = reference_chop_control;
            `IOCR_COMPARATOR_CONTROL_STATUS: next_rdata = {3'h0, comp_int_enable, comp_now};
            `IOCR_ANALOG_MISC_CONTROL: next_rdata = analog_misc_control;
            `IOCR_CONVERTER_POWER_CONTROL: next_rdata = converter_power_control;
            `IOCR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
            `IOCR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            default: begin
               if (pair_base(addr) != 4'hF)
                  next_rdata = pack_pair(pin_resource_selector[pair_base(addr)],
                     pin_resource_selector[pair_base(addr) + 4'h1]);
            end
         endcase
      end
   end

   // read data stand for the one cycle after the strobe
   always @(posedge clk or posedge reset) begin
      if (reset)
         rdata <= 8'h00;
      else
         rdata <= next_rdata;
   end

   // comparator and pin history for edge detection
   // history starts at the idle low level so reset makes no false edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_status <= 2'h0;
         comp_prev <= 3'h0;
         pin_prev <= 12'h000;
      end else begin
         irq_status <= next_irq_status;
         comp_prev <= comp_now;
         pin_prev <= pin_now;
      end
   end

   // analog control outputs
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         converter_disable <= 1'b0;
         converter_bias_off <= 1'b0;
         engine_enable <= 1'b0;
         reference_chop_enable <= 1'b0;
         analog_misc <= 8'h00;
      end else begin
         // RL1 converter power down
         converter_disable <= converter_power_control[`IOCR_CONVERTER_DISABLE_BIT];
         converter_bias_off <= converter_power_control[`IOCR_CONVERTER_DISABLE_BIT];
         engine_enable <= engine_control[`IOCR_ENGINE_ENABLE_BIT];
         // RL2 chop decode
         reference_chop_enable <= ~(reference_chop_control[`IOCR_CHOP_HI_BIT] ^
            reference_chop_control[`IOCR_CHOP_LO_BIT]);
         analog_misc <= analog_misc_control;
      end
   end

   // routed pin outputs
   // pin pulses shorter than a clock period may be missed
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         counter0_clock_input <= 1'b0;
         counter1_clock_input <= 1'b0;
         high_priority_pin_interrupt <= 1'b0;
         low_priority_pin_interrupt <= 1'b0;
      end else begin
         // RL9 counter clock routing
         counter0_clock_input <= |c0;
         counter1_clock_input <= |c1;
         // RL10 edge events as one cycle pulses
         high_priority_pin_interrupt <= |hp_r;
         low_priority_pin_interrupt <= |lp_r;
      end
   end

   // level interrupt, aligned with the status it reflects
   // both outputs carry the same level
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         comparator_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         comparator_irq <= |(next_irq_status & irq_mask);
         irq <= |(next_irq_status & irq_mask);
      end
   end
endmodule
`default_nettype wire

// File: bench/iocr_config_slice_props.sv
// port assertions for the configuration slice
`timescale 1ns/100ps
`default_nettype none
module iocr_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic converter_disable,
   input wire logic converter_bias_off,
   input wire logic reference_chop_enable,
   input wire logic [7:0] analog_misc,
   input wire logic irq,
   input wire logic comparator_irq,
   input wire logic high_priority_pin_interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_disable_follows_write:
      assert property (wr && addr == 16'h2005 |-> ##2 converter_disable == $past(wdata[3], 2))
      else $error("converter disable wrong");
   a_bias_off_tied:
      assert property (converter_bias_off == converter_disable) else $error("bias off wrong");
   a_chop_decode:
      assert property (wr && addr == 16'h2002 |-> ##2
         reference_chop_enable == ($past(wdata[5], 2) == $past(wdata[4], 2)))
      else $error("chop decode wrong");
   a_misc_reserved_clear:
      assert property (wr && addr == 16'h2004 |-> ##2 analog_misc == ($past(wdata, 2) & 8'hDF))
      else $error("misc byte wrong");
   a_route_pad_zero:
      assert property (rd && addr >= 16'h2009 && addr <= 16'h200E |=> (rdata & 8'h88) == 8'h00)
      else $error("route byte padding set");
   a_state_top_zero:
      assert property (rd && addr == 16'h2003 |=> rdata[7:5] == 3'h0)
      else $error("state byte top set");
   a_enable_readback:
      assert property (wr && addr == 16'h2003 ##1 !wr ##1 rd && addr == 16'h2003 |=>
         rdata[4:3] == $past(wdata[4:3], 3))
      else $error("enable readback wrong");
   a_irq_tied:
      assert property (irq == comparator_irq) else $error("irq outputs differ");
   c_conv_write: cover property (wr && addr == 16'h2005);
   c_irq_rise: cover property ($rose(irq));
   c_hp_pulse: cover property (high_priority_pin_interrupt);
endmodule
bind iocr_config_slice iocr_props p (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
   .converter_disable, .converter_bias_off, .reference_chop_enable, .analog_misc, .irq,
   .comparator_irq, .high_priority_pin_interrupt);
`default_nettype wire

// File: bench/test_iocr_config_slice.sv
// self-checking bench for the configuration slice
`timescale 1ns/100ps
`default_nettype none
module test_iocr_config_slice;
   logic clk = 0, reset = 1, wr = 0, rd = 0;
   logic first_comparator = 0, second_comparator = 0, third_comparator = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [11:0] pin_in = 12'h000;
   logic [1:0] seen = 2'b00;
   logic seen_clr = 1'b0;
   wire logic [7:0] rdata, analog_misc;
   wire logic converter_disable, converter_bias_off, engine_enable, reference_chop_enable;
   wire logic counter0_clock_input, counter1_clock_input, comparator_irq, irq;
   wire logic high_priority_pin_interrupt, low_priority_pin_interrupt;
   int err_count = 0, num_checks = 0;
   logic [15:0] regs [13] = '{16'h2000, 16'h2002, 16'h2003, 16'h2004, 16'h2005, 16'h2009,
      16'h200A, 16'h200B, 16'h200C, 16'h200D, 16'h200E, 16'h2010, 16'h2011};
   iocr_config_slice uut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
      .first_comparator, .second_comparator, .third_comparator, .pin_in,
      .converter_disable, .converter_bias_off, .engine_enable, .reference_chop_enable,
      .analog_misc, .counter0_clock_input, .counter1_clock_input,
      .high_priority_pin_interrupt, .low_priority_pin_interrupt, .comparator_irq, .irq);
   always #4 clk = ~clk;
   always @(posedge clk) begin
      if (seen_clr)
         seen <= 2'b00;
      else
         seen <= seen | {high_priority_pin_interrupt, low_priority_pin_interrupt};
   end
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // derived outputs follow one edge after the write lands
      @(posedge clk);
      #1;
   endtask
   task rchk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("rdata_%h", a), e, rdata);
   endtask
   // comparator levels settle through sync and edge detect
   task setc(input logic [2:0] v);
      @(posedge clk);
      {third_comparator, second_comparator, first_comparator} <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task setp(input logic [11:0] v);
      @(posedge clk);
      pin_in <= v;
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      foreach (regs[i]) rchk(regs[i], 8'h00);
      wreg(16'h2005, 8'h08);
      chk("converter_disable", 8'h01, 8'(converter_disable));
      chk("bias_off", 8'h01, 8'(converter_bias_off));
      rchk(16'h2005, 8'h08);
      wreg(16'h2000, 8'hFF);
      chk("engine_enable", 8'h01, 8'(engine_enable));
      for (int k = 0; k < 4; k++) begin
         wreg(16'h2002, 8'(k << 4));
         chk("chop", 8'(k == 0 || k == 3), 8'(reference_chop_enable));
      end
      wreg(16'h2004, 8'hFF);
      chk("analog_misc", 8'hDF, analog_misc);
      rchk(16'h2004, 8'hDF);
      for (int k = 0; k < 6; k++) begin
         wreg(16'h2009 + 16'(k), 8'hFF);
         rchk(16'h2009 + 16'(k), 8'h77);
      end
      wreg(16'h2001, 8'hFF);
      rchk(16'h2001, 8'h00);
      wreg(16'h2011, 8'h03);
      wreg(16'h2003, 8'hFF);
      rchk(16'h2003, 8'h18);
      wreg(16'h2003, 8'h08);
      setc(3'b101);
      rchk(16'h2003, 8'h0D);
      rchk(16'h2010, 8'h00);
      setc(3'b111);
      rchk(16'h2010, 8'h01);
      chk("irq", 8'h01, 8'(irq));
      chk("comparator_irq", 8'h01, 8'(comparator_irq));
      wreg(16'h2011, 8'h00);
      chk("irq_masked", 8'h00, 8'(irq));
      wreg(16'h2010, 8'h01);
      rchk(16'h2010, 8'h00);
      wreg(16'h2011, 8'h03);
      wreg(16'h2003, 8'h10);
      setc(3'b011);
      rchk(16'h2010, 8'h02);
      wreg(16'h2010, 8'h02);
      wreg(16'h2003, 8'h18);
      setc(3'b101);
      rchk(16'h2010, 8'h00);
      setc(3'b001);
      rchk(16'h2010, 8'h01);
      wreg(16'h2009, 8'h22);
      wreg(16'h200A, 8'h30);
      setp(12'h002);
      chk("counter0", 8'h01, 8'(counter0_clock_input));
      chk("counter1", 8'h00, 8'(counter1_clock_input));
      setp(12'h009);
      chk("counter01", 8'h03, 8'({counter1_clock_input, counter0_clock_input}));
      wreg(16'h200A, 8'h10);
      chk("reserved", 8'h01, 8'({counter1_clock_input, counter0_clock_input}));
      setp(12'h000);
      for (int k = 4; k < 8; k++) begin
         wreg(16'h200E, 8'(k << 4));
         setp(12'h800);
         chk("rise", 8'({k == 4, k == 5}), 8'(seen));
         setp(12'h000);
         chk("fall", 8'({k == 6, k == 7}), 8'(seen));
      end
      end_of_test;
   end
endmodule
`default_nettype wire
